// ==== common/ext_irq_pkg.sv ====
// package: register map, field layout, reset values for external interrupt detect
//
// Operation
// - priority register: bit1 port match, bit0 regulator
// - per-input polarity bit, 1 is active high
// - per-input edge select, 1 edge, 0 level
// - each input routed from its selected pin
// - three-bit pin select, code n picks port0 pin n
// - pin choice independent of crossbar assignment
// - pin monitoring is read-only, never drives pins
// - pending flags at timer control bits 1 and 3
// - edge mode pending cleared on vector acknowledge
// - level mode pending follows active input level
package ext_irq_pkg;
  localparam logic [7:0] aux_interrupt_priority_addr = 8'hf7;
  localparam logic [7:0] ext_irq_config_addr = 8'he4;
  localparam logic [7:0] timer_control_reg_addr = 8'h88;
  localparam logic [7:0] irq_status_addr = 8'hf8;
  localparam logic [7:0] irq_mask_addr = 8'hf9;
  localparam logic [7:0] aux_interrupt_priority_reset = 8'h00;
  localparam logic [7:0] ext_irq_config_reset = 8'h01;
  localparam logic [7:0] timer_control_reg_reset = 8'h00;
  localparam logic [7:0] aux_priority_used = 8'h03;
  localparam int port_match_priority_bit = 1;
  localparam int regulator_dropout_priority_bit = 0;
  localparam int a_edge_bit = 0;
  localparam int a_pending_bit = 1;
  localparam int b_edge_bit = 2;
  localparam int b_pending_bit = 3;
  localparam int a_sel_lsb = 0;
  localparam int a_pol_bit = 3;
  localparam int b_sel_lsb = 4;
  localparam int b_pol_bit = 7;
  localparam int sel_width = 3;
  localparam int port_width = 8;

  // settings of one external input
  typedef struct packed {
    logic polarity;
    logic edge_select;
    logic [2:0] pin_select;
  } irq_cfg_t;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

// ==== rtl/ext_irq_channel.sv ====
// one external interrupt channel: pin select, sync, edge or level detect
`timescale 1ns/100ps
`default_nettype none
module ext_irq_channel (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] port_pins,
  input wire ext_irq_pkg::irq_cfg_t cfg,
  input wire logic ack,
  output logic pending,
  output logic activation
);
  logic selected;
  logic sync1;
  logic sync2;
  logic active_q;
  logic edge_flag;
  logic next_edge_flag;
  logic active_now;

  // pin chosen straight from port 0, no crossbar involved
  assign selected = port_pins[cfg.pin_select];
  // polarity maps synchronized pin to active level
  assign active_now = cfg.polarity ? sync2 : ~sync2;
  assign activation = active_now & ~active_q;

  // edge flag: set on activation beats vector clear
  always_comb begin
    next_edge_flag = edge_flag;
    if (ack)
      next_edge_flag = 1'b0;
    if (activation)
      next_edge_flag = 1'b1;
  end

  // two-stage synchronizer, then history and flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      active_q <= 1'b1; // no false edge while the sync refills
      edge_flag <= 1'b0;
    end else begin
      sync1 <= selected;
      sync2 <= sync1;
      active_q <= active_now;
      edge_flag <= next_edge_flag;
    end
  end

  // level mode shows live input, edge mode the latched flag
  assign pending = cfg.edge_select ? edge_flag : active_now;

  level_follow_a: assert property (@(posedge clk)
    disable iff (!rst_b)
    !cfg.edge_select && $past(rst_b, 2) |->
    pending == ($past(selected, 2) == cfg.polarity))
    else $error("level pending does not follow input");
  edge_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    cfg.edge_select && activation && $stable(cfg.edge_select) |=> edge_flag)
    else $error("edge activation did not set flag");
  ack_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    ack && !activation |=> !edge_flag)
    else $error("vector acknowledge did not clear flag");
  sync_delay_a: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) && $stable(cfg) ##1 $stable(cfg) |->
    sync2 == $past(selected, 2))
    else $error("synchronizer latency wrong");
  edge_cov: cover property (@(posedge clk) disable iff (!rst_b)
    cfg.edge_select && activation ##[1:20] ack);
  level_cov: cover property (@(posedge clk) disable iff (!rst_b)
    !cfg.edge_select && pending ##1 !pending);
endmodule
`default_nettype wire

// ==== rtl/external_interrupt_detect.sv ====
// external interrupt detect: config, timer control flags, priority, status
`timescale 1ns/100ps
`default_nettype none
module external_interrupt_detect (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [7:0] port_pins,
  input wire logic ack_a,
  input wire logic ack_b,
  output logic ext_irq_a_pending,
  output logic ext_irq_b_pending,
  output logic port_match_priority,
  output logic regulator_dropout_priority,
  output logic irq
);
  ext_irq_pkg::reg_req_t req;
  logic [7:0] aux_interrupt_priority;
  logic [7:0] next_aux_interrupt_priority;
  logic [7:0] ext_irq_config;
  logic [7:0] next_ext_irq_config;
  logic [7:0] timer_control_reg;
  logic [7:0] next_timer_control_reg;
  logic [1:0] irq_status;
  logic [1:0] next_irq_status;
  logic [1:0] irq_mask;
  logic [1:0] next_irq_mask;
  logic [7:0] next_rdata;
  logic [7:0] timer_control_view;
  ext_irq_pkg::irq_cfg_t cfg_a;
  ext_irq_pkg::irq_cfg_t cfg_b;
  logic act_a;
  logic act_b;
  logic ack_a_edge;
  logic ack_b_edge;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // per-input settings drawn from config and timer control
  assign cfg_a = '{polarity: ext_irq_config[ext_irq_pkg::a_pol_bit],
    edge_select: timer_control_reg[ext_irq_pkg::a_edge_bit],
    pin_select: ext_irq_config[ext_irq_pkg::a_sel_lsb +: 3]};
  assign cfg_b = '{polarity: ext_irq_config[ext_irq_pkg::b_pol_bit],
    edge_select: timer_control_reg[ext_irq_pkg::b_edge_bit],
    pin_select: ext_irq_config[ext_irq_pkg::b_sel_lsb +: 3]};

  // vector acknowledge only clears in edge mode
  assign ack_a_edge = ack_a & cfg_a.edge_select;
  assign ack_b_edge = ack_b & cfg_b.edge_select;

  ext_irq_channel u_chan_a (
    .clk(clk),
    .rst_b(rst_b),
    .port_pins(port_pins),
    .cfg(cfg_a),
    .ack(ack_a_edge),
    .pending(ext_irq_a_pending),
    .activation(act_a)
  );

  ext_irq_channel u_chan_b (
    .clk(clk),
    .rst_b(rst_b),
    .port_pins(port_pins),
    .cfg(cfg_b),
    .ack(ack_b_edge),
    .pending(ext_irq_b_pending),
    .activation(act_b)
  );

  // priority outputs from the auxiliary priority register
  assign port_match_priority =
    aux_interrupt_priority[ext_irq_pkg::port_match_priority_bit];
  assign regulator_dropout_priority =
    aux_interrupt_priority[ext_irq_pkg::regulator_dropout_priority_bit];

  // timer control as read: pending flags placed at bits 1 and 3
  always_comb begin
    timer_control_view = timer_control_reg;
    timer_control_view[ext_irq_pkg::a_pending_bit] = ext_irq_a_pending;
    timer_control_view[ext_irq_pkg::b_pending_bit] = ext_irq_b_pending;
  end

  // register writes and sticky status
  always_comb begin
    next_aux_interrupt_priority = aux_interrupt_priority;
    next_ext_irq_config = ext_irq_config;
    next_timer_control_reg = timer_control_reg;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    if (req.wr) begin
      case (req.addr)
        ext_irq_pkg::aux_interrupt_priority_addr: begin
          // unused bits stay zero
          next_aux_interrupt_priority =
            req.wdata & ext_irq_pkg::aux_priority_used;
        end
        ext_irq_pkg::ext_irq_config_addr: begin
          next_ext_irq_config = req.wdata;
        end
        ext_irq_pkg::timer_control_reg_addr: begin
          // pending bits are hardware owned, not stored
          next_timer_control_reg = req.wdata;
          next_timer_control_reg[ext_irq_pkg::a_pending_bit] = 1'b0;
          next_timer_control_reg[ext_irq_pkg::b_pending_bit] = 1'b0;
        end
        ext_irq_pkg::irq_mask_addr: begin
          next_irq_mask = req.wdata[1:0];
        end
        ext_irq_pkg::irq_status_addr: begin
          next_irq_status = irq_status & ~req.wdata[1:0];
        end
        default: begin
          next_irq_mask = irq_mask;
        end
      endcase
    end
    // set wins over write-one-to-clear
    if (act_a)
      next_irq_status[0] = 1'b1;
    if (act_b)
      next_irq_status[1] = 1'b1;
  end

  // read data: one cycle after the read strobe, unmapped reads zero
  always_comb begin
    next_rdata = 8'h00;
    if (req.rd) begin
      case (req.addr)
        ext_irq_pkg::aux_interrupt_priority_addr:
          next_rdata = aux_interrupt_priority;
        ext_irq_pkg::ext_irq_config_addr:
          next_rdata = ext_irq_config;
        ext_irq_pkg::timer_control_reg_addr:
          next_rdata = timer_control_view;
        ext_irq_pkg::irq_status_addr:
          next_rdata = {6'h00, irq_status};
        ext_irq_pkg::irq_mask_addr:
          next_rdata = {6'h00, irq_mask};
        default:
          next_rdata = 8'h00;
      endcase
    end
  end

  // register state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_interrupt_priority <= ext_irq_pkg::aux_interrupt_priority_reset;
      ext_irq_config <= ext_irq_pkg::ext_irq_config_reset;
      timer_control_reg <= ext_irq_pkg::timer_control_reg_reset;
      irq_status <= 2'h0;
      irq_mask <= 2'h0;
      rdata <= 8'h00;
    end else begin
      aux_interrupt_priority <= next_aux_interrupt_priority;
      ext_irq_config <= next_ext_irq_config;
      timer_control_reg <= next_timer_control_reg;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      rdata <= next_rdata;
    end
  end

  // level interrupt from unmasked sticky status
  assign irq = |(irq_status & irq_mask);

  prio_unused_a: assert property (@(posedge clk) disable iff (!rst_b)
    (aux_interrupt_priority & ~ext_irq_pkg::aux_priority_used) == 8'h00)
    else $error("unused priority bits not zero");
  prio_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && req.addr == ext_irq_pkg::aux_interrupt_priority_addr |=>
    port_match_priority == $past(wdata[1]) &&
    regulator_dropout_priority == $past(wdata[0]))
    else $error("priority write not applied");
  flag_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && req.addr == ext_irq_pkg::timer_control_reg_addr |=>
    rdata[1] == $past(ext_irq_a_pending) &&
    rdata[3] == $past(ext_irq_b_pending))
    else $error("pending flags misplaced in timer control");
  status_sticky_a: assert property (@(posedge clk) disable iff (!rst_b)
    act_a |=> irq_status[0])
    else $error("activation did not set status");
  irq_level_a: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && req.addr == ext_irq_pkg::irq_mask_addr &&
    req.wdata[1:0] == 2'h0 |=> !irq)
    else $error("interrupt output mismatch");

  // second status bit and write-one-to-clear
  status_b_a: assert property (@(posedge clk) disable iff (!rst_b)
    act_b |=> irq_status[1])
    else $error("activation did not set second status bit");
  status_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && req.addr == ext_irq_pkg::irq_status_addr && req.wdata[0] &&
    !act_a |=> !irq_status[0])
    else $error("status bit not cleared by write of one");

  // configuration writes land, and hold when not written
  cfg_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && req.addr == ext_irq_pkg::ext_irq_config_addr |=>
    ext_irq_config == $past(wdata))
    else $error("config write not applied");
  cfg_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    !(req.wr && req.addr == ext_irq_pkg::ext_irq_config_addr) |=>
    $stable(ext_irq_config))
    else $error("config changed without a write");

  // sensitivity bits follow timer control writes, pending bits never stored
  edge_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && req.addr == ext_irq_pkg::timer_control_reg_addr |=>
    cfg_a.edge_select == $past(wdata[ext_irq_pkg::a_edge_bit]) &&
    cfg_b.edge_select == $past(wdata[ext_irq_pkg::b_edge_bit]))
    else $error("sensitivity write not applied");
  flag_store_a: assert property (@(posedge clk) disable iff (!rst_b)
    !timer_control_reg[ext_irq_pkg::a_pending_bit] &&
    !timer_control_reg[ext_irq_pkg::b_pending_bit])
    else $error("pending bits stored as plain register");

  // vector acknowledge and activation as seen at the pending outputs
  edge_ack_a: assert property (@(posedge clk) disable iff (!rst_b)
    cfg_a.edge_select && ack_a && !act_a |=>
    !cfg_a.edge_select || !ext_irq_a_pending)
    else $error("first pending not cleared on vector");
  edge_ack_b: assert property (@(posedge clk) disable iff (!rst_b)
    cfg_b.edge_select && ack_b && !act_b |=>
    !cfg_b.edge_select || !ext_irq_b_pending)
    else $error("second pending not cleared on vector");
  edge_set_b_a: assert property (@(posedge clk) disable iff (!rst_b)
    cfg_b.edge_select && act_b ##1 cfg_b.edge_select |->
    ext_irq_b_pending)
    else $error("second edge activation not pending");

  // priority register reads and holds, read data zero outside a read
  prio_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && req.addr == ext_irq_pkg::aux_interrupt_priority_addr |=>
    rdata[7:2] == 6'h00)
    else $error("unused priority bits read nonzero");
  prio_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    !(req.wr && req.addr == ext_irq_pkg::aux_interrupt_priority_addr) |=>
    $stable(aux_interrupt_priority))
    else $error("priority changed without a write");
  rdata_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
    !req.rd |=> rdata == 8'h00)
    else $error("read data outside read cycle");

  irq_cov: cover property (@(posedge clk) disable iff (!rst_b)
    irq ##[1:10] !irq);
  prio_cov: cover property (@(posedge clk) disable iff (!rst_b)
    port_match_priority && regulator_dropout_priority);
  both_cov: cover property (@(posedge clk) disable iff (!rst_b)
    ext_irq_a_pending && ext_irq_b_pending);
endmodule
`default_nettype wire

// ==== bench/irq_source.sv ====
// external interrupt source model driving the port 0 pins
`timescale 1ns/100ps
`default_nettype none
module irq_source (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2:0] pin_idx,
  input wire logic active_high,
  input wire logic fire,
  input wire logic ack,
  output logic [7:0] port_pins
);
  logic held;
  logic next_held;
  // hold the request until the core vectors, then drop it
  always_comb begin
    next_held = held;
    if (ack) begin
      next_held = 1'b0;
    end else if (fire) begin
      next_held = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      held <= 1'b0;
    end else begin
      held <= next_held;
    end
  end
  // pins kept for interrupts only, idle at the inactive level
  assign port_pins = {8{~active_high}} ^ ({7'h00, held} << pin_idx);
endmodule
`default_nettype wire

// ==== bench/external_interrupt_detect_bench.sv ====
// self-checking bench for the external interrupt detect block
`timescale 1ns/100ps
`default_nettype none
module external_interrupt_detect_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ack_a = 1'b0;
  logic ack_b = 1'b0;
  logic fire = 1'b0;
  logic pol = 1'b0;
  logic [2:0] pin_idx = 3'h0;
  logic rd_d = 1'b0;
  logic [7:0] rdata, port_pins, d;
  logic pend_a, pend_b, pm_pri, rg_pri, irq;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h0000be96;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #25 clk = ~clk;

  external_interrupt_detect dut (.clk(clk), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .port_pins(port_pins),
    .ack_a(ack_a), .ack_b(ack_b), .ext_irq_a_pending(pend_a),
    .ext_irq_b_pending(pend_b), .port_match_priority(pm_pri),
    .regulator_dropout_priority(rg_pri), .irq(irq));
  irq_source partner (.clk(clk), .rst_b(rst_b), .pin_idx(pin_idx),
    .active_high(pol), .fire(fire), .ack(ack_a | ack_b),
    .port_pins(port_pins));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic pulse(input logic on_b, input logic fire_pin);
    @(posedge clk);
    ack_a <= !on_b && !fire_pin;
    ack_b <= on_b && !fire_pin;
    fire <= fire_pin;
    @(posedge clk);
    ack_a <= 1'b0;
    ack_b <= 1'b0;
    fire <= 1'b0;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // read data appear in the cycle after the strobe only
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d) chk("rdata", rdata, exp_q.pop_front());
  end

  // cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    wait_cyc(4);
    rd_reg(8'hf7, 8'h00);
    rd_reg(8'he4, 8'h01);
    rd_reg(8'h88, 8'h00);
    rd_reg(8'h00, 8'h00);
    seed = xs(seed);
    wr_reg(8'hf7, seed[7:0]);
    rd_reg(8'hf7, seed[7:0] & 8'h03);
    wait_cyc(1);
    chk("pm_pri", pm_pri, seed[1]);
    chk("rg_pri", rg_pri, seed[0]);
    wr_reg(8'hf9, 8'h03);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      d = {seed[0], i[2:0], seed[0], i[2:0]};
      @(posedge clk);
      pol <= seed[0];
      pin_idx <= i[2:0];
      wr_reg(8'he4, d);
      wr_reg(8'h88, 8'h05);
      wait_cyc(4);
      pulse(1'b0, 1'b0);
      pulse(1'b1, 1'b0);
      wr_reg(8'hf8, 8'h03);
      wait_cyc(1);
      chk("pend_a", pend_a, 1'b0);
      chk("irq", irq, 1'b0);
      pulse(1'b0, 1'b1);
      wait_cyc(4);
      chk("pend_a", pend_a, 1'b1);
      chk("pend_b", pend_b, 1'b1);
      chk("irq", irq, 1'b1);
      rd_reg(8'h88, 8'h0f);
      pulse(1'b0, 1'b0);
      @(negedge clk);
      chk("pend_a", pend_a, 1'b0);
      chk("pend_b", pend_b, 1'b1);
      pulse(1'b1, 1'b0);
      @(negedge clk);
      chk("pend_b", pend_b, 1'b0);
    end
    wr_reg(8'hf9, 8'h00);
    wr_reg(8'h88, 8'h00);
    wait_cyc(4);
    wr_reg(8'hf8, 8'h03);
    pulse(1'b0, 1'b1);
    wait_cyc(3);
    chk("pend_a", pend_a, 1'b1);
    chk("pend_b", pend_b, 1'b1);
    chk("irq", irq, 1'b0);
    wr_reg(8'hf9, 8'h01);
    wait_cyc(1);
    chk("irq", irq, 1'b1);
    pulse(1'b0, 1'b0);
    @(negedge clk);
    chk("pend_a", pend_a, 1'b1);
    wait_cyc(3);
    chk("pend_a", pend_a, 1'b0);
    chk("pend_b", pend_b, 1'b0);
    wr_reg(8'hf8, 8'h01);
    wait_cyc(1);
    chk("irq", irq, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
